// file: rtl/parity_pkg.sv
// constants, register map and parity helpers for the parity control block
package parity_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DMA_DIAG = 8'h08;
	localparam logic [7:0] OFS_DMA_CFG = 8'h0C;
	localparam logic [7:0] OFS_SCSI_DIAG = 8'h10;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTRL_GEN = 0;
	localparam int CTRL_CHECK = 1;
	localparam int CTRL_SCSI_EVEN = 2;
	localparam int CTRL_HOST_EVEN = 3;
	localparam int CTRL_ATN = 4;
	localparam int CTRL_IRQ = 5;
	localparam int CTRL_HALT = 6;
	localparam int CTRL_W = 7;
	localparam logic [6:0] CTRL_RST = 7'h00;
	// ------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------
	localparam int ST_ERR = 0;
	localparam int ST_LIVE = 1;
	localparam int ST_LATCHED = 2;
	localparam int ST_DMA_PAR = 3;
	localparam int ST_SCSI_PAR = 4;
	// ------------------------------------------------------------
	// dma fifo config and shape
	// ------------------------------------------------------------
	localparam int CFG_PAR = 2;
	localparam int DIAG_EMPTY = 9;
	localparam int LANES = 4;
	localparam int LANE_DEPTH = 16;
	localparam int ENTRY_W = 9;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;

	// parity bit that gives the byte the requested sense
	function automatic logic parity_of(input logic [7:0] b, input logic even);
		parity_of = (^b) ^ ~even;
	endfunction

	function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] i);
		lane_byte = w[i*8 +: 8];
	endfunction
endpackage

// file: rtl/fifo_lane_if.sv
// push/pop port of one dma fifo byte lane
`timescale 1ns/1ps
interface fifo_lane_if;
	logic push;
	logic pop;
	logic [8:0] wdata;
	logic [8:0] rdata;
	logic full;
	logic empty;
	modport lane (input push, pop, wdata, output rdata, full, empty);
	modport user (output push, pop, wdata, input rdata, full, empty);
endinterface

// file: rtl/dma_fifo_lane.sv
// one byte lane of the dma fifo: 16 entries of 9 bits
`timescale 1ns/1ps
module dma_fifo_lane (
	input wire logic clk,
	input wire logic rst_n,
	fifo_lane_if.lane bus
);
	typedef struct packed {
		logic [parity_pkg::LANE_DEPTH-1:0][parity_pkg::ENTRY_W-1:0] mem;
		logic [parity_pkg::PTR_W-1:0] wr;
		logic [parity_pkg::PTR_W-1:0] rd;
		logic [parity_pkg::CNT_W-1:0] cnt;
	} lane_s;

	lane_s st;
	lane_s next_st;
	logic do_push;
	logic do_pop;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	assign bus.full = (st.cnt == parity_pkg::CNT_W'(parity_pkg::LANE_DEPTH));
	assign bus.empty = (st.cnt == '0);
	assign bus.rdata = st.mem[st.rd];
	assign do_push = bus.push & ~bus.full;
	assign do_pop = bus.pop & ~bus.empty;

	always_comb begin
		next_st = st;
		if (do_push) begin
			next_st.mem[st.wr] = bus.wdata;
			next_st.wr = st.wr + 1'b1;
		end
		if (do_pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		if (do_push & ~do_pop) begin
			next_st.cnt = st.cnt + 1'b1;
		end else if (do_pop & ~do_push) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// file: rtl/scsi_host_parity_control.sv
// parity generation, pass-through and checking between host bus and scsi bus
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// - parity error flag sets on any scsi or host parity error
// - status shows the live scsi parity line level
// - status holds parity captured with the scsi input latch byte
// - dma fifo diagnostic pop shows the popped entry's parity bit
// - write-only bit supplies parity for diagnostic dma fifo writes
// - scsi fifo diagnostic pop shows that entry's parity bit
// - checking disabled: no checks, never a parity error
// - generation off: parity flows host to scsi and scsi to host
// - generation on: host lines 2-0 ignored, line 3 is abort_n, scsi parity generated
// - generation on: received scsi parity never driven onto host lines
// - scsi even setting picks even or odd parity for scsi sends
// - generation off: host even setting picks host parity sense
// - check, no generation: scsi received odd, host sends per host sense
// - check and generation: only received scsi data, always odd
// - dma fifo is four lanes of 16 nine-bit entries
// - each dma fifo lane reads back diagnostic writes in order
// - initiator with attention setting asserts attention on parity error
// - interrupt enable gates request; error flag sets regardless
// - target mode halt setting halts operation on parity error
module scsi_host_parity_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] scsi_data_pins,
	input wire logic scsi_parity_line_in,
	output logic scsi_parity_line_out,
	output logic scsi_parity_line_oe,
	input wire logic [31:0] host_data_pins,
	input wire logic [3:0] host_parity_lines_in,
	output logic [3:0] host_parity_lines_out,
	output logic [3:0] host_parity_lines_oe,
	input wire logic send_active,
	input wire logic send_strobe,
	input wire logic [7:0] send_byte,
	input wire logic [1:0] send_lane,
	input wire logic recv_active,
	input wire logic recv_strobe,
	input wire logic [1:0] recv_lane,
	input wire logic host_word_valid,
	input wire logic [3:0] host_lane_en,
	input wire logic is_initiator,
	input wire logic is_target,
	input wire logic [8:0] scsi_fifo_rdata,
	input wire logic scsi_fifo_empty,
	output logic scsi_fifo_pop,
	output logic host_abort,
	output logic atn_assert,
	output logic halt_request,
	output logic parity_irq,
	output logic [7:0] latch_byte
);
	typedef struct packed {
		logic [7:0] sd1;
		logic [7:0] sd2;
		logic sp1;
		logic sp2;
		logic [31:0] hd1;
		logic [31:0] hd2;
		logic [3:0] hp1;
		logic [3:0] hp2;
		logic [6:0] ctrl;
		logic [1:0] lane_sel;
		logic dma_par_wr;
		logic err;
		logic [7:0] lbyte;
		logic lpar;
		logic dma_pop_par;
		logic scsi_pop_par;
		logic scsi_par_out;
		logic [3:0] host_par_out;
		logic abort;
		logic atn;
		logic halt;
		logic [31:0] rdata;
		logic slverr;
	} state_s;

	state_s st;
	state_s next_st;

	fifo_lane_if lane_bus[parity_pkg::LANES] ();
	logic [parity_pkg::LANES-1:0][8:0] lane_rdata;
	logic [parity_pkg::LANES-1:0] lane_full;
	logic [parity_pkg::LANES-1:0] lane_empty;
	logic [parity_pkg::LANES-1:0] lane_push;
	logic [parity_pkg::LANES-1:0] lane_pop;
	logic [8:0] lane_wdata;

	logic gen;
	logic chk;
	logic scsi_even;
	logic host_even;
	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic scsi_err;
	logic host_err;
	logic err_event;
	logic [3:0] lane_bad;
	logic [8:0] head;
	logic hit_status;
	logic hit_dma_diag;
	logic hit_scsi_diag;

	// ------------------------------------------------------------
	// dma fifo lanes
	// ------------------------------------------------------------
	// each lane is a fifo of its own, so a diagnostic pass can test one byte lane alone
	for (genvar i = 0; i < parity_pkg::LANES; i++) begin : g_lane
		dma_fifo_lane u_lane (
			.clk(pclk),
			.rst_n(presetn),
			.bus(lane_bus[i])
		);
		assign lane_bus[i].push = lane_push[i];
		assign lane_bus[i].pop = lane_pop[i];
		assign lane_bus[i].wdata = lane_wdata;
		assign lane_rdata[i] = lane_bus[i].rdata;
		assign lane_full[i] = lane_bus[i].full;
		assign lane_empty[i] = lane_bus[i].empty;
	end

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	assign gen = st.ctrl[parity_pkg::CTRL_GEN];
	assign chk = st.ctrl[parity_pkg::CTRL_CHECK];
	assign scsi_even = st.ctrl[parity_pkg::CTRL_SCSI_EVEN];
	assign host_even = st.ctrl[parity_pkg::CTRL_HOST_EVEN];
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign head = lane_rdata[st.lane_sel];
	assign lane_wdata = {st.dma_par_wr, pwdata[7:0]};
	// address hits shared by the push, pop and clear paths
	assign hit_status = (paddr == parity_pkg::OFS_STATUS);
	assign hit_dma_diag = (paddr == parity_pkg::OFS_DMA_DIAG);
	assign hit_scsi_diag = (paddr == parity_pkg::OFS_SCSI_DIAG);

	// pops land at the access edge, after the head was captured at setup
	always_comb begin
		lane_push = '0;
		lane_pop = '0;
		if (wr_acc && hit_dma_diag) begin
			lane_push[st.lane_sel] = 1'b1;
		end
		if (rd_acc && hit_dma_diag) begin
			lane_pop[st.lane_sel] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// parity checks
	// ------------------------------------------------------------
	always_comb begin
		lane_bad = '0;
		for (int i = 0; i < parity_pkg::LANES; i++) begin
			lane_bad[i] = host_lane_en[i] & (st.hp2[i] !=
				parity_pkg::parity_of(parity_pkg::lane_byte(st.hd2, 2'(i)), host_even));
		end
	end

	// received scsi data is always checked for odd parity
	assign scsi_err = chk & recv_strobe &
		(st.sp2 != parity_pkg::parity_of(st.sd2, 1'b0));
	// host data is checked only while parity flows through
	assign host_err = chk & ~gen & host_word_valid & (|lane_bad);
	assign err_event = scsi_err | host_err;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		// two-flop synchronisers on the scsi and host data and parity pins; only the second stage feeds logic
		next_st.sd1 = scsi_data_pins;
		next_st.sd2 = st.sd1;
		next_st.sp1 = scsi_parity_line_in;
		next_st.sp2 = st.sp1;
		next_st.hd1 = host_data_pins;
		next_st.hd2 = st.hd1;
		next_st.hp1 = host_parity_lines_in;
		next_st.hp2 = st.hp1;

		if (recv_strobe) begin
			next_st.lbyte = st.sd2;
			next_st.lpar = st.sp2;
			// scsi parity is odd, so a host set to even sees it inverted
			next_st.host_par_out[recv_lane] = st.sp2 ^ host_even;
		end

		// flow-through re-encodes the host bit into the scsi sense;
		// with equal senses the bit passes unchanged
		if (send_strobe) begin
			if (gen) begin
				next_st.scsi_par_out = parity_pkg::parity_of(send_byte, scsi_even);
			end else begin
				next_st.scsi_par_out = st.hp2[send_lane] ^ host_even ^ scsi_even;
			end
		end

		next_st.abort = gen & ~st.hp2[3];
		next_st.halt = err_event & is_target & st.ctrl[parity_pkg::CTRL_HALT];

		if (wr_acc) begin
			case (paddr)
				parity_pkg::OFS_CTRL: begin
					next_st.ctrl = pwdata[parity_pkg::CTRL_W-1:0];
				end
				parity_pkg::OFS_DMA_CFG: begin
					next_st.lane_sel = pwdata[1:0];
					next_st.dma_par_wr = pwdata[parity_pkg::CFG_PAR];
				end
				default: begin
				end
			endcase
		end

		// write one clears; a new error in the same cycle wins
		if (wr_acc && hit_status && pwdata[parity_pkg::ST_ERR]) begin
			next_st.err = 1'b0;
		end
		if (err_event) begin
			next_st.err = 1'b1;
		end
		next_st.atn = next_st.err & is_initiator & st.ctrl[parity_pkg::CTRL_ATN];

		if (rd_acc && hit_dma_diag && !lane_empty[st.lane_sel]) begin
			next_st.dma_pop_par = head[8];
		end
		if (rd_acc && hit_scsi_diag && !scsi_fifo_empty) begin
			next_st.scsi_pop_par = scsi_fifo_rdata[8];
		end

		// read data and error are prepared in the setup phase
		if (setup) begin
			next_st.rdata = '0;
			next_st.slverr = 1'b0;
			case (paddr)
				parity_pkg::OFS_CTRL: begin
					next_st.rdata[parity_pkg::CTRL_W-1:0] = st.ctrl;
				end
				parity_pkg::OFS_STATUS: begin
					next_st.rdata[parity_pkg::ST_ERR] = st.err;
					next_st.rdata[parity_pkg::ST_LIVE] = st.sp2;
					next_st.rdata[parity_pkg::ST_LATCHED] = st.lpar;
					next_st.rdata[parity_pkg::ST_DMA_PAR] = st.dma_pop_par;
					next_st.rdata[parity_pkg::ST_SCSI_PAR] = st.scsi_pop_par;
				end
				parity_pkg::OFS_DMA_DIAG: begin
					next_st.rdata[7:0] = lane_empty[st.lane_sel] ? 8'h00 : head[7:0];
					next_st.rdata[parity_pkg::DIAG_EMPTY] = lane_empty[st.lane_sel];
					next_st.rdata[parity_pkg::DIAG_EMPTY+1] = lane_full[st.lane_sel];
				end
				parity_pkg::OFS_DMA_CFG: begin
					// parity bit is write-only
					next_st.rdata[1:0] = st.lane_sel;
				end
				parity_pkg::OFS_SCSI_DIAG: begin
					next_st.rdata[7:0] = scsi_fifo_empty ? 8'h00 : scsi_fifo_rdata[7:0];
					next_st.rdata[parity_pkg::DIAG_EMPTY] = scsi_fifo_empty;
				end
				default: begin
					next_st.slverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.ctrl <= parity_pkg::CTRL_RST;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = st.slverr;
	assign scsi_fifo_pop = rd_acc & hit_scsi_diag & ~scsi_fifo_empty;
	assign scsi_parity_line_out = st.scsi_par_out;
	assign scsi_parity_line_oe = send_active;
	assign host_parity_lines_out = st.host_par_out;
	// received parity stays internal while generation is on
	assign host_parity_lines_oe = {4{recv_active & ~gen}};
	assign host_abort = st.abort;
	assign atn_assert = st.atn;
	assign halt_request = st.halt;
	assign parity_irq = st.err & st.ctrl[parity_pkg::CTRL_IRQ];
	assign latch_byte = st.lbyte;
endmodule

// file: test/parity_chk.sv
// port assertions for the parity control block
`timescale 1ns/1ps
module parity_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0] send_byte,
	input wire logic send_strobe,
	input wire logic send_active,
	input wire logic recv_active,
	input wire logic is_initiator,
	input wire logic [3:0] host_parity_lines_in,
	input wire logic scsi_parity_line_out,
	input wire logic scsi_parity_line_oe,
	input wire logic [3:0] host_parity_lines_oe,
	input wire logic scsi_fifo_pop,
	input wire logic host_abort,
	input wire logic atn_assert,
	input wire logic parity_irq
);
	logic [6:0] c;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// control shadow; pready is always high, so every access edge lands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c <= 7'h00;
		end else if (psel && penable && pwrite && paddr == parity_pkg::OFS_CTRL) begin
			c <= pwdata[6:0];
		end
	end
	property p_soe;
		scsi_parity_line_oe == send_active;
	endproperty
	a_soe: assert property (p_soe) else $error("scsi oe");
	property p_hoe;
		|host_parity_lines_oe |-> recv_active && !c[0];
	endproperty
	a_hoe: assert property (p_hoe) else $error("host oe");
	property p_gen;
		send_strobe && c[0] |=> scsi_parity_line_out == (^$past(send_byte) ^ !$past(c[2]));
	endproperty
	a_gen: assert property (p_gen) else $error("gen parity");
	property p_abort_on;
		(c[0] && !host_parity_lines_in[3]) [*5] |-> host_abort;
	endproperty
	a_abort_on: assert property (p_abort_on) else $error("abort on");
	property p_abort_off;
		!c[0] ##1 !c[0] |-> !host_abort;
	endproperty
	a_abort_off: assert property (p_abort_off) else $error("abort off");
	property p_irq;
		parity_irq |-> c[5];
	endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_atn;
		atn_assert |-> $past(is_initiator) && $past(c[4]);
	endproperty
	a_atn: assert property (p_atn) else $error("atn");
	property p_pop;
		scsi_fifo_pop |-> psel && penable && !pwrite && paddr == parity_pkg::OFS_SCSI_DIAG;
	endproperty
	a_pop: assert property (p_pop) else $error("scsi pop");
endmodule
bind scsi_host_parity_control parity_chk parity_chk_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.send_byte(send_byte),
	.send_strobe(send_strobe),
	.send_active(send_active),
	.recv_active(recv_active),
	.is_initiator(is_initiator),
	.host_parity_lines_in(host_parity_lines_in),
	.scsi_parity_line_out(scsi_parity_line_out),
	.scsi_parity_line_oe(scsi_parity_line_oe),
	.host_parity_lines_oe(host_parity_lines_oe),
	.scsi_fifo_pop(scsi_fifo_pop),
	.host_abort(host_abort),
	.atn_assert(atn_assert),
	.parity_irq(parity_irq)
);

// file: test/scsi_peer.sv
// scsi peer model: drives the scsi data bus and holds a small scsi fifo
`timescale 1ns/1ps
module scsi_peer (
	input wire logic pclk,
	input wire logic drive,
	input wire logic load,
	input wire logic pop,
	input wire logic [8:0] val,
	output logic [7:0] pins,
	output logic par,
	output logic [8:0] head,
	output logic empty
);
	logic [8:0] last = 9'h000;
	logic [8:0] mem [0:7];
	logic [2:0] rp = 3'h0;
	logic [2:0] wp = 3'h0;
	always @(posedge pclk) begin
		if (drive) last <= val;
		if (load) mem[wp] <= val;
		if (load) wp <= wp + 3'h1;
		if (pop && !empty) rp <= rp + 3'h1;
	end
	// released bus shows the inverse of the last byte so stale data never passes
	assign {par, pins} = drive ? val : ~last;
	assign empty = rp == wp;
	assign head = empty ? ~last : mem[rp];
endmodule

// file: test/scsi_host_parity_control_tb_top.sv
// self-checking bench for the parity control block
`timescale 1ns/1ps
module scsi_host_parity_control_tb_top;
	localparam logic [7:0] CT = parity_pkg::OFS_CTRL;
	localparam logic [7:0] ST = parity_pkg::OFS_STATUS;
	localparam logic [7:0] DD = parity_pkg::OFS_DMA_DIAG;
	localparam logic [7:0] DC = parity_pkg::OFS_DMA_CFG;
	localparam logic [7:0] SD = parity_pkg::OFS_SCSI_DIAG;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, scsi_parity_line_in, scsi_parity_line_out, scsi_parity_line_oe;
	logic [7:0] paddr = 8'h00, send_byte = 8'h00, scsi_data_pins, latch_byte;
	logic [31:0] pwdata = 32'h0, prdata, host_data_pins = 32'h0;
	logic [3:0] host_parity_lines_in = 4'h0, host_lane_en = 4'h0;
	logic [3:0] host_parity_lines_out, host_parity_lines_oe;
	logic send_active = 1'b0, send_strobe = 1'b0, recv_active = 1'b0, recv_strobe = 1'b0;
	logic host_word_valid = 1'b0, is_initiator = 1'b0, is_target = 1'b0, drive = 1'b0;
	logic [1:0] send_lane = 2'h0, recv_lane = 2'h0;
	logic [8:0] scsi_fifo_rdata, val = 9'h000;
	logic scsi_fifo_empty, scsi_fifo_pop, host_abort, atn_assert, halt_request, parity_irq;
	logic load = 1'b0, send_d = 1'b0;
	logic [32:0] eq[$];
	logic [32:0] mq[$];
	logic sq[$];
	logic hq[$];
	int failures = 0, checks_done = 0;
	initial forever #25 pclk = ~pclk;
	scsi_host_parity_control scsi_host_parity_control_i (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.scsi_data_pins(scsi_data_pins),
		.scsi_parity_line_in(scsi_parity_line_in),
		.scsi_parity_line_out(scsi_parity_line_out),
		.scsi_parity_line_oe(scsi_parity_line_oe),
		.host_data_pins(host_data_pins),
		.host_parity_lines_in(host_parity_lines_in),
		.host_parity_lines_out(host_parity_lines_out),
		.host_parity_lines_oe(host_parity_lines_oe),
		.send_active(send_active),
		.send_strobe(send_strobe),
		.send_byte(send_byte),
		.send_lane(send_lane),
		.recv_active(recv_active),
		.recv_strobe(recv_strobe),
		.recv_lane(recv_lane),
		.host_word_valid(host_word_valid),
		.host_lane_en(host_lane_en),
		.is_initiator(is_initiator),
		.is_target(is_target),
		.scsi_fifo_rdata(scsi_fifo_rdata),
		.scsi_fifo_empty(scsi_fifo_empty),
		.scsi_fifo_pop(scsi_fifo_pop),
		.host_abort(host_abort),
		.atn_assert(atn_assert),
		.halt_request(halt_request),
		.parity_irq(parity_irq),
		.latch_byte(latch_byte)
	);
	scsi_peer scsi_peer_i (.pclk(pclk), .drive(drive), .load(load), .pop(scsi_fifo_pop),
		.val(val), .pins(scsi_data_pins), .par(scsi_parity_line_in),
		.head(scsi_fifo_rdata), .empty(scsi_fifo_empty));
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e, input logic [32:0] m);
		int n;
		n = 0;
		if (!w) begin
			eq.push_back(e & m);
			mq.push_back(m);
		end
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				failures++;
				close_out();
			end
			@(posedge pclk);
		end
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	// the watcher takes the oldest note whenever a read or a send result shows
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && eq.size() > 0)
			chk("read", eq.pop_front(), {pslverr, prdata} & mq.pop_front());
		if (send_d) begin
			chk("scsi parity", sq.pop_front(), scsi_parity_line_out);
			chk("halt", hq.pop_front(), halt_request);
		end
		send_d <= send_strobe;
	end
	initial begin
		repeat (90000) @(posedge pclk);
		failures++;
		close_out();
	end
	initial begin
		logic [7:0] b, sb;
		logic [3:0] p, le;
		logic sp, err, ini;
		logic [8:0] ent [0:16];
		int c, k;
		void'($urandom(22754));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, CT, 0, 33'h0, 33'h7F);
		apb(0, ST, 0, 33'h0, 33'h19);
		apb(0, 8'h40, 0, 33'h1_0000_0000, 33'h1_0000_0000);
		$display("test reset done");
		for (c = 0; c < 16; c++) begin
			b = 8'($urandom);
			sb = 8'($urandom);
			p = 4'($urandom);
			le = 4'($urandom);
			sp = 1'($urandom);
			ini = 1'($urandom);
			err = c[1] & (~^{sb, sp} | ~c[0] & |(le & ~({4{^b ^ c[3]}} ^ p)));
			apb(1, CT, 32'h70 | c, 0, 0);
			{is_initiator, is_target, host_parity_lines_in, host_lane_en} <= {ini, sp, p, le};
			{host_data_pins, val, drive, send_byte} <= {{4{b}}, sp, sb, 1'b1, b};
			{send_lane, recv_lane, send_active, recv_active} <= {c[1:0], c[3:2], 2'b11};
			repeat (4) @(posedge pclk);
			{send_strobe, recv_strobe, host_word_valid} <= 3'b111;
			sq.push_back(c[0] ? ^b ^ ~c[2] : p[c[1:0]] ^ c[3] ^ c[2]);
			hq.push_back(err & sp);
			@(posedge pclk);
			{send_strobe, recv_strobe, host_word_valid} <= 3'b000;
			repeat (3) @(posedge pclk);
			if (!c[0]) chk("host parity", sp ^ c[3], host_parity_lines_out[c[3:2]]);
			chk("host oe", {4{~c[0]}}, host_parity_lines_oe);
			chk("latch", sb, latch_byte);
			chk("abort", c[0] & ~p[3], host_abort);
			chk("irq", err, parity_irq);
			chk("atn", err & ini, atn_assert);
			apb(0, ST, 0, {sp, sp, err}, 33'h7);
			apb(1, ST, 1, 0, 0);
			apb(0, ST, 0, 0, 33'h1);
			{drive, send_active, recv_active} <= 3'b000;
		end
		$display("test parity modes done");
		for (c = 0; c < 4; c++) begin
			for (k = 0; k < 17; k++) begin
				ent[k] = 9'($urandom);
				apb(1, DC, {ent[k][8], c[1:0]}, 0, 0);
				apb(1, DD, ent[k][7:0], 0, 0);
			end
			apb(0, DC, 0, c, 33'h7);
			for (k = 0; k < 17; k++) begin
				apb(0, DD, 0, k < 16 ? {k == 0, 2'h0, ent[k][7:0]} : 33'h200, 33'h6FF);
				if (k < 16) apb(0, ST, 0, {ent[k][8], 3'h0}, 33'h8);
			end
		end
		for (k = 0; k < 4; k++) begin
			ent[k] = 9'($urandom);
			{val, load} <= {ent[k], 1'b1};
			@(posedge pclk);
			load <= 1'b0;
			@(posedge pclk);
		end
		for (k = 0; k < 5; k++) begin
			apb(0, SD, 0, k < 4 ? {1'b0, ent[k][7:0]} : 33'h200, 33'h2FF);
			if (k < 4) apb(0, ST, 0, {ent[k][8], 4'h0}, 33'h10);
		end
		$display("test fifo diagnostics done");
		close_out();
	end
endmodule
